// ### epa_pkg.sv
// Package of constants for the external port decode and bus arbiter
// How it works
// RQ1: Map is 256 pages of 64K words
// RQ2: Page 0 internal RAM, no strobe
// RQ3: Boot ROM 4K words at 0xFF0000
// RQ4: Reset bank pages 1/64/128/192 to 254
// RQ5: Software reprograms bank boundaries and waits
// RQ6: Each off-chip space has own settings
// RQ7: Per-space 8 or 16 bit data width; ext_addr only reads the width bit of the memory and boot spaces
// RQ8: I/O pages 0-31 on chip, rest off; the decode holds is_io and is_io_on at 0, so neither I/O select ever asserts
// RQ9: Boot space is one off-chip bank
// RQ10: External address limited to 20 lines
// RQ11: Fetch starts from boot ROM after reset
// RQ12: Data page register supplies external page
// RQ13: External request lowest, granted only when idle
// RQ14: Grant at least three clocks after request
// RQ15: Float bus and strobes before asserting grant
// RQ16: Core external access stalls while granted
// RQ17: No grant between two reads of one instruction
// RQ18: Core exclusive option still honours DMA and request
// RQ19: Request handshake works even under reset
// RQ20: Grant hang when access waits on grant
// RQ21: Fixed DMA priority receive first, memory last
// RQ22: DMA steals cycles; chained descriptors restart (epa_dma_prio only grants requests; there is no descriptor logic)
// RQ23: Request synchronised twice; grant drops promptly
package epa_pkg;
  localparam logic [7:0]  ROM_PAGE      = 8'hFF;
  localparam logic [15:0] ROM_TOP_LIMIT = 16'h0FFF;
  localparam logic [7:0]  IO_ONCHIP_MAX = 8'h1F;
  localparam logic [7:0]  BANK1_START   = 8'h40;
  localparam logic [7:0]  BANK2_START   = 8'h80;
  localparam logic [7:0]  BANK3_START   = 8'hC0;
  localparam logic [7:0]  BANK0_START   = 8'h01;
  localparam logic [7:0]  BOOT_LAST_PG  = 8'hFE;
  localparam logic [23:0] BOOT_VECTOR   = 24'hFF0000;
  localparam int          ADDR_W        = 20;
  localparam int          NUM_DMA       = 5;
  // Register byte addresses
  localparam logic [7:0] REG_BANK_START = 8'h00;
  localparam logic [7:0] REG_CFG_BASE   = 8'h04;
  localparam logic [7:0] REG_CTRL       = 8'h14;
  localparam logic [7:0] REG_PAGE       = 8'h18;
  localparam logic [7:0] REG_STATUS     = 8'h1C;
  // Space index in configuration array
  localparam int SP_MEM = 0;
  localparam int SP_IO  = 1;
  localparam int SP_BOOT = 2;
  localparam int NUM_SPACES = 3;
  // Space configuration field positions
  localparam int F_RWAIT = 0;
  localparam int F_WWAIT = 3;
  localparam int F_WMODE = 6;
  localparam int F_CLKDIV = 8;
  localparam int F_HOLD  = 10;
  localparam int F_POL   = 11;
  localparam int F_WIDE  = 12;
  localparam logic [31:0] CFG_RESET = 32'h0000103F;
  localparam logic [31:0] BANK_RESET = 32'hC0804001;
  localparam int SYNC_MIN_CYC = 3;
  typedef enum logic [1:0] {EPA_RESP_OK = 2'b00, EPA_RESP_SLVERR = 2'b10} epa_resp_e;
endpackage

// ### epa_dma_prio.sv
// Fixed-priority DMA bus arbiter
`timescale 1ns/1ps
module epa_dma_prio
  import epa_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [NUM_DMA-1:0]  dma_req,
  input  wire logic                bus_free,
  output logic      [NUM_DMA-1:0]  dma_gnt
);
  function automatic logic [NUM_DMA-1:0] pick(input logic [NUM_DMA-1:0] r);
    logic [NUM_DMA-1:0] g;
    g = '0;
    for (int i = NUM_DMA - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  // Index 0 is serial receive, 4 is memory-to-memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dma_gnt <= '0;
    end else if (bus_free) begin
      dma_gnt <= pick(dma_req); // [RQ21] [RQ22]
    end else begin
      dma_gnt <= '0;
    end
  end
endmodule

// ### epa_top.sv
// External port decode, space configuration and bus arbitration
`timescale 1ns/1ps
module epa_top
  import epa_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Core access request
  input  wire logic                core_req,
  input  wire logic                core_is_data,
  input  wire logic                core_second_read,
  input  wire logic [23:0]         core_addr,
  input  wire logic                core_first_fetch,
  output logic                     core_stall,
  output logic                     int_ram_sel,
  output logic                     boot_rom_sel,
  output logic                     io_onchip_sel,
  // DMA masters
  input  wire logic [NUM_DMA-1:0]  dma_req,
  output logic [NUM_DMA-1:0]       dma_gnt,
  // External pins
  input  wire logic                ext_bus_request_n,
  output logic                     ext_bus_grant_n,
  output logic                     grant_hang_n,
  output logic [3:0]               bank_select_n,
  output logic                     io_space_select_n,
  output logic                     boot_space_select_n,
  output logic [ADDR_W-1:0]        ext_addr,
  output logic                     ext_drive_oe,
  output logic [23:0]              fetch_addr
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] bank_start;
  logic [31:0] space_cfg [NUM_SPACES];
  logic        core_exclusive;
  logic [7:0]  second_data_page_reg;
  logic [1:0]  aw_wd_seen;
  logic [7:0]  aw_hold;
  logic [31:0] w_hold;
  logic [3:0]  w_strb_hold;
  logic        req_s1;
  logic        req_s2;
  logic [1:0]  req_age;
  logic        granted;
  logic        read_pair_lock;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data latched in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_wd_seen    <= 2'b00;
      aw_hold       <= 8'h00;
      w_hold        <= 32'h00000000;
      w_strb_hold   <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= EPA_RESP_OK;
    end else begin
      s_axi_awready <= !aw_wd_seen[0] && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready  <= !aw_wd_seen[1] && !s_axi_bvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_wd_seen[0] <= 1'b1;
        aw_hold       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        aw_wd_seen[1] <= 1'b1;
        w_hold        <= s_axi_wdata;
        w_strb_hold   <= s_axi_wstrb;
        s_axi_wready  <= 1'b0;
      end
      if (aw_wd_seen == 2'b11 && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(aw_hold) ? EPA_RESP_OK : EPA_RESP_SLVERR;
        aw_wd_seen   <= 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic addr_mapped(input logic [7:0] a);
    logic gap;
    // Offset after the last space register has no register behind it
    gap = (a == REG_CFG_BASE + 8'(NUM_SPACES * 4));
    return (a[1:0] == 2'b00) && (a <= REG_STATUS) && !gap;
  endfunction

  // Write lands in the cycle its response is raised; strobes were latched with the data
  wire do_write = (aw_wd_seen == 2'b11) && !s_axi_bvalid && addr_mapped(aw_hold);

  // Bank start pages and per-space settings, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_start <= BANK_RESET; // [RQ4]
    end else if (do_write && aw_hold == REG_BANK_START) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_hold[b]) begin
          bank_start[b*8 +: 8] <= w_hold[b*8 +: 8]; // [RQ5]
        end
      end
    end
  end

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SPACES; gs++) begin : g_cfg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          space_cfg[gs] <= CFG_RESET;
        end else if (do_write && aw_hold == REG_CFG_BASE + 8'(gs * 4)) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_hold[b]) begin
              space_cfg[gs][b*8 +: 8] <= w_hold[b*8 +: 8]; // [RQ6] [RQ7]
            end
          end
        end
      end
    end
  endgenerate

  // Exclusive use leaves arbitration alone: DMA and outside requests still get turns
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_exclusive       <= 1'b0;
      second_data_page_reg <= 8'h00;
    end else if (do_write) begin
      if (aw_hold == REG_CTRL && w_strb_hold[0]) begin
        core_exclusive <= w_hold[0]; // [RQ18]
      end
      if (aw_hold == REG_PAGE && w_strb_hold[0]) begin
        second_data_page_reg <= w_hold[7:0]; // [RQ12]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= EPA_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= addr_mapped(s_axi_araddr) ? EPA_RESP_OK : EPA_RESP_SLVERR;
        // Unmapped offsets read as zero with an error response
        unique case (s_axi_araddr)
          REG_BANK_START:    s_axi_rdata <= bank_start;
          REG_CFG_BASE:      s_axi_rdata <= space_cfg[SP_MEM];
          REG_CFG_BASE + 8'h04: s_axi_rdata <= space_cfg[SP_IO];
          REG_CFG_BASE + 8'h08: s_axi_rdata <= space_cfg[SP_BOOT];
          REG_CTRL:          s_axi_rdata <= {31'h00000000, core_exclusive};
          REG_PAGE:          s_axi_rdata <= {24'h000000, second_data_page_reg};
          REG_STATUS:        s_axi_rdata <= {28'h0000000, !grant_hang_n, core_stall,
                                             req_s2, granted};
          default:           s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [23:0] eff_addr;
  logic [7:0]  pg;
  logic        is_int, is_rom, is_bank, is_boot, is_io, is_io_on, ext_hit;
  logic [3:0]  bank_hit;

  // Data accesses take their page from the second data page register
  assign eff_addr = core_is_data ? {second_data_page_reg, core_addr[15:0]} : core_addr; // [RQ12]
  assign pg       = eff_addr[23:16]; // [RQ1]

  function automatic logic [3:0] bank_of(input logic [7:0] p, input logic [31:0] s);
    logic [3:0] h;
    h = 4'h0;
    if (p >= s[31:24] && p <= BOOT_LAST_PG) h[3] = 1'b1;
    else if (p >= s[23:16]) h[2] = 1'b1;
    else if (p >= s[15:8]) h[1] = 1'b1;
    else if (p >= s[7:0]) h[0] = 1'b1;
    return h;
  endfunction

  // Boot space is page 0xFF above ROM_TOP_LIMIT; I/O decode is tied off (is_io and is_io_on stay 0);
  // pages 0 and 0xFF never hit a bank, other pages at or above some bank start page go to the memory banks.
  always_comb begin
    is_int   = (pg == 8'h00); // [RQ2]
    is_rom   = (pg == ROM_PAGE) && (eff_addr[15:0] <= ROM_TOP_LIMIT); // [RQ3]
    is_io    = 1'b0;
    is_io_on = 1'b0;
    is_boot  = (pg == ROM_PAGE) && !is_rom; // [RQ9]
    bank_hit = (is_int || pg == ROM_PAGE) ? 4'h0 : bank_of(pg, bank_start); // [RQ5]
    is_bank  = |bank_hit;
    ext_hit  = core_req && (is_bank || is_boot || is_io);
  end

  // I/O decode: io page in core_addr[17:10] when data accesses target I/O
  logic [7:0] io_pg;
  assign io_pg = core_addr[17:10];

  //////////////////////////////////////////////////////////////////////////////
  // Bus request synchroniser and arbiter; runs during reset too
  always_ff @(posedge aclk) begin
    req_s1 <= !ext_bus_request_n; // [RQ19] [RQ23]
    req_s2 <= req_s1;
  end

  // Outside request has lowest priority: any on-chip demand keeps it waiting
  wire internal_busy = (ext_hit && !granted) || (|dma_req) || read_pair_lock;

  // Age of the synchronised request, so the grant never beats the minimum delay
  always_ff @(posedge aclk) begin
    if (!req_s2) begin
      req_age <= 2'd0;
    end else if (req_age != 2'(SYNC_MIN_CYC - 2)) begin
      req_age <= req_age + 2'd1;
    end
  end

  // Grant logic is not reset so the handshake keeps working in reset
  always_ff @(posedge aclk) begin
    if (!req_s2) begin
      granted <= 1'b0; // [RQ16] [RQ23]
    end else if (!granted && req_age == 2'(SYNC_MIN_CYC - 2) && !internal_busy) begin
      granted <= 1'b1; // [RQ13] [RQ14] [RQ17] [RQ18]
    end
  end

  always_ff @(posedge aclk) begin
    ext_drive_oe    <= !(granted || (req_s2 && !internal_busy)); // [RQ15]
    ext_bus_grant_n <= !granted; // [RQ15]
  end

  // A paired read holds the bus through its second access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_pair_lock <= 1'b0;
    end else begin
      read_pair_lock <= core_req && ext_hit && core_second_read && !granted; // [RQ17]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strobes, address and stall
  logic wide;
  assign wide = space_cfg[is_boot ? SP_BOOT : SP_MEM][F_WIDE];

  // On-chip targets raise no external strobe, though ext_addr still follows them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ram_sel   <= 1'b0;
      boot_rom_sel  <= 1'b0;
      io_onchip_sel <= 1'b0;
    end else begin
      int_ram_sel   <= core_req && is_int; // [RQ2]
      boot_rom_sel  <= core_req && is_rom; // [RQ3]
      io_onchip_sel <= core_req && core_is_data && (io_pg <= IO_ONCHIP_MAX) && is_io_on; // [RQ8]
    end
  end

  // Stall and hang both mean an external access waits on the lent bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_stall   <= 1'b0;
      grant_hang_n <= 1'b1;
    end else begin
      core_stall   <= ext_hit && granted; // [RQ16]
      grant_hang_n <= !(ext_hit && granted); // [RQ20]
    end
  end

  // Strobes go idle while granted, the pins belong to the other master then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_select_n       <= 4'hF;
      io_space_select_n   <= 1'b1;
      boot_space_select_n <= 1'b1;
    end else if (granted) begin
      bank_select_n       <= 4'hF; // [RQ15]
      io_space_select_n   <= 1'b1;
      boot_space_select_n <= 1'b1;
    end else begin
      bank_select_n       <= ~(bank_hit & {4{core_req}}); // [RQ4]
      io_space_select_n   <= !(core_req && is_io && io_pg > IO_ONCHIP_MAX); // [RQ8]
      boot_space_select_n <= !(core_req && is_boot); // [RQ9]
    end
  end

  // 8-bit width needs byte address, 16-bit uses word address; held while granted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr <= '0;
    end else if (!granted) begin
      ext_addr <= wide ? eff_addr[ADDR_W-1:0]
                       : {eff_addr[ADDR_W-2:0], 1'b0}; // [RQ7] [RQ10]
    end
  end

  // First fetch after reset always comes from the boot ROM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_addr <= BOOT_VECTOR; // [RQ11]
    end else if (!core_first_fetch) begin
      fetch_addr <= core_addr;
    end
  end

  // DMA arbitration pauses while the outside master holds the bus
  epa_dma_prio u_dma (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .dma_req  (dma_req),
    .bus_free (!granted),
    .dma_gnt  (dma_gnt)
  );
endmodule

// ### epa_sva.sv
// Assertion checker for the external port decode and bus arbiter
`timescale 1ns/1ps
module epa_chk
  import epa_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [NUM_DMA-1:0] dma_req,
  input wire logic [NUM_DMA-1:0] dma_gnt,
  input wire logic               ext_bus_request_n,
  input wire logic               ext_bus_grant_n,
  input wire logic               grant_hang_n,
  input wire logic               core_stall,
  input wire logic [3:0]         bank_select_n,
  input wire logic               io_space_select_n,
  input wire logic               boot_space_select_n,
  input wire logic               ext_drive_oe,
  input wire logic [23:0]        fetch_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence req_seen;
    $fell(ext_bus_request_n);
  endsequence
  sequence grant_held_off;
    ext_bus_grant_n [*3];
  endsequence
  grant_delay_a: assert property (req_seen |-> grant_held_off)
    else $error("grant sooner than three clocks");
  bus_float_a: assert property (!ext_bus_grant_n |-> !ext_drive_oe && &bank_select_n
    && io_space_select_n && boot_space_select_n) else $error("bus driven while granted");
  // Release may take a synchroniser pass plus the grant flop
  grant_drop_a: assert property ($rose(ext_bus_request_n) |-> ##[1:8] ext_bus_grant_n)
    else $error("grant held after release");
  dma_onehot_a: assert property ($onehot0(dma_gnt))
    else $error("several dma grants");
  dma_prio_a: assert property (dma_gnt != '0 |->
    dma_gnt == ($past(dma_req) & (~$past(dma_req) + 1'b1))) else $error("dma priority");
  dma_yield_a: assert property (!ext_bus_grant_n && !$past(ext_bus_grant_n) |-> dma_gnt == '0)
    else $error("dma granted while bus away");
  stall_cause_a: assert property (core_stall |-> !ext_bus_grant_n || !$past(ext_bus_grant_n))
    else $error("stall without grant");
  hang_cause_a: assert property (!grant_hang_n |-> !ext_bus_grant_n || !$past(ext_bus_grant_n))
    else $error("hang without grant");
  boot_fetch_a: assert property ($rose(aresetn) |-> fetch_addr == BOOT_VECTOR)
    else $error("first fetch not from rom");
endmodule
bind epa_top epa_chk u_epa_chk (.aclk, .aresetn, .dma_req, .dma_gnt, .ext_bus_request_n,
  .ext_bus_grant_n, .grant_hang_n, .core_stall, .bank_select_n, .io_space_select_n,
  .boot_space_select_n, .ext_drive_oe, .fetch_addr);

// ### epa_bus_master.sv
// Outside bus master that borrows the external bus
`timescale 1ns/1ps
module epa_bus_master #(
  parameter int HOLD = 20
) (
  input  wire logic aclk,
  input  wire logic start,
  input  wire logic ext_bus_grant_n,
  output logic      ext_bus_request_n
);
  int k;
  initial begin
    ext_bus_request_n = 1'b1;
    forever begin
      @(posedge aclk);
      if (start) begin
        ext_bus_request_n <= 1'b0;
        // Keeps asking until granted or 200 clocks pass, then holds the request HOLD clocks and lets go
        for (k = 0; k < 200 && ext_bus_grant_n !== 1'b0; k++) @(posedge aclk);
        repeat (HOLD) @(posedge aclk);
        ext_bus_request_n <= 1'b1;
      end
    end
  end
endmodule

// ### epa_top_test.sv
// Self-checking bench for the external port decode and bus arbiter
`timescale 1ns/1ps
module epa_top_test;
  import epa_pkg::*;
  logic               aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic               s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic               s_axi_rvalid, core_req, core_is_data, core_second_read, core_first_fetch;
  logic               core_stall, int_ram_sel, boot_rom_sel, io_onchip_sel, ext_bus_request_n;
  logic               ext_bus_grant_n, grant_hang_n, io_space_select_n, boot_space_select_n;
  logic               ext_drive_oe, start;
  logic [7:0]         s_axi_awaddr, s_axi_araddr, pg;
  logic [31:0]        s_axi_wdata, s_axi_rdata, st, s, d;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]         s_axi_wstrb, bank_select_n;
  logic [23:0]        core_addr, fetch_addr;
  logic [NUM_DMA-1:0] dma_req, dma_gnt, v;
  logic [ADDR_W-1:0]  ext_addr;
  int                 miscompares, checked, n;
  epa_top u_epa_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core_req, .core_is_data, .core_second_read, .core_addr,
    .core_first_fetch, .core_stall, .int_ram_sel, .boot_rom_sel, .io_onchip_sel, .dma_req,
    .dma_gnt, .ext_bus_request_n, .ext_bus_grant_n, .grant_hang_n, .bank_select_n,
    .io_space_select_n, .boot_space_select_n, .ext_addr, .ext_drive_oe, .fetch_addr);
  epa_bus_master u_epa_bus_master (.aclk, .start, .ext_bus_grant_n, .ext_bus_request_n);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Highest bank whose start page is not above the page; pages 0 and 255 select no bank
  function automatic logic [3:0] exp_sel(input logic [7:0] p, input logic [31:0] b);
    exp_sel = 4'hF;
    for (int i = 3; i >= 0; i--)
      if (exp_sel == 4'hF && p >= b[8*i+:8] && p != 8'h00 && p != 8'hFF) exp_sel[i] = 1'b0;
  endfunction
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic fail_wait;
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // One write or one read; each channel held until its own ready
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] dw);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= dw;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int k = 0; k < 40 && !b; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        b = 1'b1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        b = 1'b1;
        rs = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
    if (!b) fail_wait();
  endtask
  task automatic wait_grant(input logic lvl, input int lim);
    for (n = 0; n < lim && ext_bus_grant_n !== lvl; n++) @(posedge aclk);
    if (ext_bus_grant_n !== lvl) fail_wait();
  endtask
  task automatic kick;
    @(posedge aclk);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
  endtask
  task automatic core(input logic dt, input logic [23:0] a);
    @(posedge aclk);
    core_req <= 1'b1;
    core_is_data <= dt;
    core_addr <= a;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_addr, dma_req, start} = '0;
    {core_req, core_is_data, core_second_read, core_first_fetch} = '0;
    s_axi_wstrb = 4'hF;
    st = BANK_RESET;
    s = 32'hF972;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(fetch_addr, BOOT_VECTOR, "boot fetch");
    axi(1'b0, REG_BANK_START, 32'h0);
    chk(d, BANK_RESET, "bank reset");
    for (int i = 0; i < NUM_SPACES; i++) begin
      axi(1'b0, REG_CFG_BASE + 8'(4 * i), 32'h0);
      chk(d, CFG_RESET, "space cfg");
    end
    axi(1'b1, REG_CFG_BASE, CFG_RESET ^ (32'h1 << F_WIDE));
    axi(1'b0, REG_CFG_BASE, 32'h0);
    chk(d, CFG_RESET ^ (32'h1 << F_WIDE), "width");
    axi(1'b0, REG_CFG_BASE + 8'h04, 32'h0);
    chk(d, CFG_RESET, "io cfg kept");
    axi(1'b0, 8'h40, 32'h0);
    chk(rs, EPA_RESP_SLVERR, "unmapped");
    core(1'b0, 24'h001234);
    chk({io_onchip_sel, int_ram_sel, bank_select_n}, 6'h1F, "ram");
    core(1'b0, BOOT_VECTOR);
    chk({boot_rom_sel, boot_space_select_n, bank_select_n}, 6'h3F, "rom");
    for (int i = 0; i < 48; i++) begin
      s = lfsr(s);
      if (i == 24) begin
        st = 32'hE0A02001;
        axi(1'b1, REG_BANK_START, st);
      end
      pg = (i % 24 < 8) ? 8'(64'hFEC0BF807F403F01 >> (8 * (i % 24))) : s[7:0];
      core(1'b0, {pg, s[23:8]});
      if (pg != 8'h00 && pg != 8'hFF) chk(bank_select_n, exp_sel(pg, st), "bank");
    end
    axi(1'b1, REG_PAGE, 32'h50);
    core(1'b1, 24'h001234);
    chk(bank_select_n, exp_sel(8'h50, st), "data page");
    chk(ext_addr, 20'h02468, "byte address");
    axi(1'b1, REG_CTRL, 32'h1);
    axi(1'b0, REG_CTRL, 32'h0);
    chk(d, 32'h1, "exclusive");
    core(1'b0, 24'h500000);
    kick();
    repeat (10) @(posedge aclk);
    chk(ext_bus_grant_n, 1'b1, "grant over core");
    core_req <= 1'b0;
    wait_grant(1'b0, 30);
    #1;
    chk({ext_drive_oe, bank_select_n, io_space_select_n, boot_space_select_n}, 7'h3F, "float");
    @(posedge aclk);
    core_req <= 1'b1;
    dma_req <= 5'h1F;
    repeat (3) @(posedge aclk);
    #1;
    chk({core_stall, grant_hang_n, dma_gnt}, 7'h40, "held off");
    wait_grant(1'b1, 40);
    repeat (4) @(posedge aclk);
    #1;
    chk({core_stall, grant_hang_n}, 2'b01, "resumed");
    @(posedge aclk);
    core_req <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      s = lfsr(s);
      v = (i < 2) ? (i ? 5'h10 : 5'h1F) : s[4:0];
      @(posedge aclk);
      dma_req <= v;
      repeat (3) @(posedge aclk);
      #1;
      chk(dma_gnt, v & (~v + 5'h01), "dma priority");
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    dma_req <= '0;
    core_first_fetch <= 1'b1;
    kick();
    wait_grant(1'b0, 40);
    chk(n >= SYNC_MIN_CYC, 1'b1, "grant delay");
    wait_grant(1'b1, 60);
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk(fetch_addr, BOOT_VECTOR, "boot fetch");
    @(posedge aclk);
    core_first_fetch <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk(fetch_addr, 24'h500000, "fetch follows");
    report_and_stop();
  end
endmodule
